// File: core/cbt_top.sv
// CAN bit timing, receiver and transmitter flag registers behind AXI4-Lite.
// Assumes bus_rx and core inputs are synchronous to mclk; core events are pulses.
// What this block does
// - Triple sample takes majority of three samples
// - Phase lengths decode as field plus one
// - Bit time is prescaler times quanta count
// - Bit timing writable only during soft reset
// - Receiver flags clear by writing one
// - Clear ignored while setting condition persists
// - Resets clear and hold receiver flags
// - Sleep bus activity sets wakeup flag
// - Receive count above 96 sets warning
// - Transmit count above 96 sets warning
// - Receive count above 127 sets passive
// - Transmit count above 127 sets passive
// - Bus-off above 255, clearable only after recovery
// - Overrun sets sticky overrun flag
// - Full foreground blocks background move
// - Flags reach interrupts only when enabled
// - Interrupt enables held during soft reset
// - Abort flags read-only, empty flags W1C
// - Resets restore transmit flags; per-buffer enables
// - Soft reset aborts traffic and synchronisation
`timescale 1ns/1ps
module cbt_top
  import cbt_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_rx,
  input wire cbt_core_status_t core_status,
  input wire cbt_core_event_t core_event,
  output logic sampled_bit,
  output logic bit_tick,
  output logic bus_synced,
  output logic soft_reset_out,
  output logic fg_load,
  output logic [2:0] abort_request,
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_receive,
  output logic irq_transmit
);
  // Register state
  logic soft_q, soft_d;
  logic [7:0] bt_q, bt_d;
  logic [5:0] presc_q, presc_d;
  logic [7:0] rflg_q, rflg_d;
  logic [7:0] rier_q, rier_d;
  logic [2:0] txe_q, txe_d, abort_acknowledge_flags_q, abort_acknowledge_flags_d, abtrq_q, abtrq_d, txeie_q, txeie_d;
  logic bg_full_q, bg_full_d;
  // AXI state
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic awready_q, wready_q, bvalid_q, bvalid_d, arready_q, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Bit timing engine state
  logic [5:0] tq_cnt_q;
  logic [4:0] q_cnt_q;
  logic [1:0] hist_q;
  logic triple_sample_select_q, triple_sample_select_tick_q, bit_tick_q;
  logic [3:0] run_q;
  logic [7:0] recov_q;
  cbt_state_t st_q, st_d;
  logic synced_q, fg_load_q;
  logic irq_wake_q, irq_err_q, irq_rx_q, irq_tx_q;

  // AXI handshake decode
  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire wr_go = aw_full_q && w_full_q && !bvalid_q;
  wire ar_take = s_axi_arvalid && arready_q;
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  wire wr_low = wr_go && wlane_q;
  wire hit_ctrl = wr_low && (aw_idx_q == CBT_IDX_CTRL);
  wire hit_presc = wr_low && (aw_idx_q == CBT_IDX_PRESC);
  wire hit_bt = wr_low && (aw_idx_q == CBT_IDX_BTIME);
  wire hit_rflg = wr_low && (aw_idx_q == CBT_IDX_RFLG);
  wire hit_rier = wr_low && (aw_idx_q == CBT_IDX_RIER);
  wire hit_tflg = wr_low && (aw_idx_q == CBT_IDX_TFLG);
  wire hit_tctrl = wr_low && (aw_idx_q == CBT_IDX_TCTRL);
  // Unmapped addresses answer with SLVERR
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == CBT_IDX_CTRL) || (idx == CBT_IDX_PRESC) || (idx == CBT_IDX_BTIME)
      || (idx == CBT_IDX_RFLG) || (idx == CBT_IDX_RIER) || (idx == CBT_IDX_TFLG)
      || (idx == CBT_IDX_TCTRL) || (idx == CBT_IDX_REC) || (idx == CBT_IDX_TEC);
  endfunction
  assign aw_full_d = (aw_full_q || aw_take) && !wr_go;
  assign w_full_d = (w_full_q || w_take) && !wr_go;
  assign bvalid_d = (bvalid_q && !s_axi_bready) || wr_go;
  assign rvalid_d = (rvalid_q && !s_axi_rready) || ar_take;

  // Read data selection
  wire [7:0] ctrl_rd = {3'h0, synced_q, 3'h0, soft_q};
  wire [7:0] tflg_rd = {1'b0, abort_acknowledge_flags_q, 1'b0, txe_q};
  wire [7:0] tctrl_rd = {1'b0, abtrq_q, 1'b0, txeie_q};
  wire [7:0] rd_byte =
    (ar_idx == CBT_IDX_CTRL) ? ctrl_rd :
    (ar_idx == CBT_IDX_PRESC) ? {2'h0, presc_q} :
    (ar_idx == CBT_IDX_BTIME) ? bt_q :
    (ar_idx == CBT_IDX_RFLG) ? rflg_q :
    (ar_idx == CBT_IDX_RIER) ? rier_q :
    (ar_idx == CBT_IDX_TFLG) ? tflg_rd :
    (ar_idx == CBT_IDX_TCTRL) ? tctrl_rd :
    (ar_idx == CBT_IDX_REC) ? core_status.rx_err_count :
    (ar_idx == CBT_IDX_TEC) ? core_status.tx_err_count[7:0] : 8'h00;

  // AXI channel registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= CBT_RESP_OKAY;
      rresp_q <= CBT_RESP_OKAY;
      rdata_q <= 32'h0;
      aw_idx_q <= 8'h00;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q <= !w_full_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (aw_take)
        aw_idx_q <= s_axi_awaddr[9:2];
      if (w_take)
      begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_go)
        bresp_q <= mapped(aw_idx_q) ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      if (ar_take)
      begin
        rdata_q <= {24'h0, rd_byte};
        rresp_q <= mapped(ar_idx) ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      end
    end
  end

  // Control, timing and enable register next values
  assign soft_d = hit_ctrl ? wbyte_q[CBT_SOFT_BIT] : soft_q;
  assign bt_d = (hit_bt && soft_q) ? wbyte_q : bt_q;
  assign presc_d = (hit_presc && soft_q) ? wbyte_q[5:0] : presc_q;
  assign rier_d = soft_q ? 8'h00 : (hit_rier ? wbyte_q : rier_q);

  // Receiver flag causes and hold conditions
  wire [8:0] rec9 = {1'b0, core_status.rx_err_count};
  wire [8:0] tec9 = core_status.tx_err_count;
  wire bus_act = core_status.sleep_mode && !bus_rx;
  wire rec_warn = rec9 > CBT_WARN_LIMIT;
  wire tec_warn = tec9 > CBT_WARN_LIMIT;
  wire rec_pass = rec9 > CBT_PASSIVE_LIMIT;
  wire tec_pass = tec9 > CBT_PASSIVE_LIMIT;
  wire tec_off = tec9 > CBT_BOFF_LIMIT;
  wire no_err = !rflg_q[CBT_RF_RERR] && !rflg_q[CBT_RF_TERR] && !rflg_q[CBT_RF_BOFF];
  wire no_boff = !rflg_q[CBT_RF_BOFF];
  wire recov_done = recov_q == CBT_RECOVERY_RUNS;
  wire bg_move = bg_full_q && !rflg_q[CBT_RF_RXF];
  wire overrun = core_event.msg_received && bg_full_q && !bg_move;
  wire [7:0] rf_set = {bus_act, rec_warn && no_err, tec_warn && no_err,
    rec_pass && no_boff, tec_pass && no_boff, tec_off, overrun, bg_move};
  wire [7:0] rf_hold = {bus_act, rec_warn, tec_warn, rec_pass, tec_pass,
    tec_off || !recov_done, 1'b0, 1'b0};
  wire [7:0] rf_clr = hit_rflg ? wbyte_q : 8'h00;
  assign bg_full_d = soft_q ? 1'b0 : ((bg_full_q && !bg_move) || core_event.msg_received);

  // Per-flag sticky logic: set wins, clear blocked while cause persists
  for (genvar i = 0; i < 8; i++)
  begin : g_rflg
    assign rflg_d[i] = soft_q ? 1'b0 :
      ((rflg_q[i] && !(rf_clr[i] && !rf_hold[i])) || rf_set[i]);
  end

  // Transmitter flags and control
  wire [2:0] txe_set = core_event.tx_sent | core_event.tx_aborted;
  wire [2:0] txe_clr = hit_tflg ? wbyte_q[2:0] : 3'h0;
  assign txe_d = soft_q ? CBT_TXE_RST : ((txe_q & ~txe_clr) | txe_set);
  assign abort_acknowledge_flags_d = soft_q ? 3'h0 : ((abort_acknowledge_flags_q & ~txe_clr) | core_event.tx_aborted);
  assign abtrq_d = soft_q ? 3'h0 : ((abtrq_q | (hit_tctrl ? wbyte_q[6:4] : 3'h0)) & ~txe_set);
  assign txeie_d = soft_q ? 3'h0 : (hit_tctrl ? wbyte_q[2:0] : txeie_q);

  // Register file update
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      soft_q <= CBT_SOFT_RST;
      bt_q <= CBT_BTIME_RST;
      presc_q <= CBT_PRESC_RST;
      rflg_q <= 8'h00;
      rier_q <= 8'h00;
      txe_q <= CBT_TXE_RST;
      abort_acknowledge_flags_q <= 3'h0;
      abtrq_q <= 3'h0;
      txeie_q <= 3'h0;
      bg_full_q <= 1'b0;
      fg_load_q <= 1'b0;
    end
    else
    begin
      soft_q <= soft_d;
      bt_q <= bt_d;
      presc_q <= presc_d;
      rflg_q <= rflg_d;
      rier_q <= rier_d;
      txe_q <= txe_d;
      abort_acknowledge_flags_q <= abort_acknowledge_flags_d;
      abtrq_q <= abtrq_d;
      txeie_q <= txeie_d;
      bg_full_q <= bg_full_d;
      fg_load_q <= bg_move && !soft_q;
    end
  end

  // Interrupt levels from flag and enable pairs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_wake_q <= 1'b0;
      irq_err_q <= 1'b0;
      irq_rx_q <= 1'b0;
      irq_tx_q <= 1'b0;
    end
    else
    begin
      irq_wake_q <= rflg_q[CBT_RF_WAKE] && rier_q[CBT_RF_WAKE];
      irq_err_q <= |(rflg_q & rier_q & CBT_ERR_MASK);
      irq_rx_q <= rflg_q[CBT_RF_RXF] && rier_q[CBT_RF_RXF];
      irq_tx_q <= |(txe_q & txeie_q);
    end
  end

  // Bit timing decode: quanta per bit = 1 + (first_phase_length + 1) + (second_phase_length + 1)
  wire [4:0] first_phase_length = {1'b0, bt_q[3:0]};
  wire [4:0] second_phase_length = {2'h0, bt_q[6:4]};
  wire [4:0] q_last = first_phase_length + second_phase_length + 5'd2;
  wire [4:0] q_triple_sample_select = first_phase_length + 5'd1;
  wire tq_tick = tq_cnt_q == presc_q;
  wire at_triple_sample_select = tq_tick && (q_cnt_q == q_triple_sample_select);
  wire at_end = tq_tick && (q_cnt_q == q_last);
  wire maj = (bus_rx && hist_q[0]) || (bus_rx && hist_q[1]) || (hist_q[0] && hist_q[1]);
  wire triple_sample_select_val = bt_q[CBT_TRIPLE_SAMPLE_SELECT_BIT] ? maj : bus_rx;
  wire run_full = at_end && triple_sample_select_q && (run_q == CBT_RECESSIVE_RUN - 4'd1);

  // Quantum prescaler, quantum counter and sampler
  always_ff @(posedge mclk)
  begin
    if (rst || soft_q)
    begin
      tq_cnt_q <= 6'h00;
      q_cnt_q <= 5'h00;
      hist_q <= 2'h3;
      triple_sample_select_q <= 1'b1;
      bit_tick_q <= 1'b0;
      triple_sample_select_tick_q <= 1'b1;
      run_q <= 4'h0;
    end
    else
    begin
      tq_cnt_q <= tq_tick ? 6'h00 : tq_cnt_q + 6'd1;
      if (tq_tick)
      begin
        q_cnt_q <= at_end ? 5'h00 : q_cnt_q + 5'd1;
        hist_q <= {hist_q[0], bus_rx};
      end
      if (at_triple_sample_select)
        triple_sample_select_q <= triple_sample_select_val;
      triple_sample_select_tick_q <= at_end ? triple_sample_select_q : triple_sample_select_tick_q;
      bit_tick_q <= at_end;
      if (at_end)
        run_q <= (!triple_sample_select_q || run_full) ? 4'h0 : run_q + 4'd1;
    end
  end

  // Bus-off recovery: count runs of recessive bits while bus-off
  always_ff @(posedge mclk)
  begin
    if (rst || !rflg_q[CBT_RF_BOFF])
      recov_q <= 8'h00;
    else if (run_full && !recov_done)
      recov_q <= recov_q + 8'd1;
  end

  // Bus synchronisation state machine
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      CBT_ST_HELD: st_d = soft_q ? CBT_ST_HELD : CBT_ST_HUNT;
      CBT_ST_HUNT:
        if (soft_q)
          st_d = CBT_ST_HELD;
        else if (run_full && (!rflg_q[CBT_RF_BOFF] || recov_done))
          st_d = CBT_ST_SYNC;
      CBT_ST_SYNC: st_d = soft_q ? CBT_ST_HELD : CBT_ST_SYNC;
      default: st_d = CBT_ST_HELD;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= CBT_ST_HELD;
      synced_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      synced_q <= st_d == CBT_ST_SYNC;
    end
  end

  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign sampled_bit = triple_sample_select_tick_q;
  assign bit_tick = bit_tick_q;
  assign bus_synced = synced_q;
  assign soft_reset_out = soft_q;
  assign fg_load = fg_load_q;
  assign abort_request = abtrq_q;
  assign irq_wakeup = irq_wake_q;
  assign irq_error = irq_err_q;
  assign irq_receive = irq_rx_q;
  assign irq_transmit = irq_tx_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_txe0_clear;
    hit_tflg && wbyte_q[0] && txe_q[0] && !txe_set[0] && !soft_q;
  endsequence

  a_bt_write_lock: assert property (hit_bt && !soft_q |=> $stable(bt_q))
    else $error("bit timing changed outside soft reset");
  a_zero_write_keep: assert property (hit_rflg && !wbyte_q[1] && rflg_q[1] && !soft_q
    |=> rflg_q[1])
    else $error("overrun flag lost on zero write");
  a_warn_clear_block: assert property (hit_rflg && wbyte_q[6] && rflg_q[6] && rec_warn
    && !soft_q |=> rflg_q[6])
    else $error("warning flag cleared while cause holds");
  a_soft_reset_hold: assert property (soft_q |=> rflg_q == 8'h00 && rier_q == 8'h00
    && txe_q == CBT_TXE_RST && abort_acknowledge_flags_q == 3'h0)
    else $error("flag registers not held in soft reset");
  a_rxf_blocks_move: assert property (rflg_q[0] |=> !fg_load_q)
    else $error("foreground loaded while full");
  a_err_irq_level: assert property (rflg_q[2] && rier_q[2] |=> irq_err_q)
    else $error("error interrupt missing");
  a_bus_off_set: assert property (tec_off && !soft_q |=> rflg_q[2] ##1 rflg_q[2])
    else $error("bus-off flag not set");
  a_txe_abort_acknowledge_flags_clear: assert property (s_txe0_clear |=> !txe_q[0] && !abort_acknowledge_flags_q[0])
    else $error("empty clear did not clear abort flag");
  a_soft_abort: assert property (soft_q |=> !synced_q ##1 !bit_tick_q)
    else $error("still synchronised in soft reset");
endmodule

// File: core/cbt_pkg.sv
// Package for the CAN bit timing and status flag block.
// Assumes a 32-bit AXI4-Lite master; each register sits in the low byte of a word.
package cbt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CBT_IDX_CTRL = 8'h00;
  localparam logic [7:0] CBT_IDX_PRESC = 8'h02;
  localparam logic [7:0] CBT_IDX_BTIME = 8'h03;
  localparam logic [7:0] CBT_IDX_RFLG = 8'h04;
  localparam logic [7:0] CBT_IDX_RIER = 8'h05;
  localparam logic [7:0] CBT_IDX_TFLG = 8'h06;
  localparam logic [7:0] CBT_IDX_TCTRL = 8'h07;
  localparam logic [7:0] CBT_IDX_REC = 8'h0e;
  localparam logic [7:0] CBT_IDX_TEC = 8'h0f;
  // Field positions
  localparam int CBT_SOFT_BIT = 0;
  localparam int CBT_SYNC_BIT = 4;
  localparam int CBT_TRIPLE_SAMPLE_SELECT_BIT = 7;
  localparam int CBT_RF_WAKE = 7;
  localparam int CBT_RF_RWRN = 6;
  localparam int CBT_RF_TWRN = 5;
  localparam int CBT_RF_RERR = 4;
  localparam int CBT_RF_TERR = 3;
  localparam int CBT_RF_BOFF = 2;
  localparam int CBT_RF_OVR = 1;
  localparam int CBT_RF_RXF = 0;
  localparam logic [7:0] CBT_ERR_MASK = 8'h7e;
  // Reset values
  localparam logic CBT_SOFT_RST = 1'b1;
  localparam logic [7:0] CBT_BTIME_RST = 8'h00;
  localparam logic [5:0] CBT_PRESC_RST = 6'h00;
  localparam logic [2:0] CBT_TXE_RST = 3'h7;
  // Error counter thresholds and recovery counts
  localparam logic [8:0] CBT_WARN_LIMIT = 9'h060;
  localparam logic [8:0] CBT_PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] CBT_BOFF_LIMIT = 9'h0ff;
  localparam logic [3:0] CBT_RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] CBT_RECOVERY_RUNS = 8'h80;
  // AXI responses
  localparam logic [1:0] CBT_RESP_OKAY = 2'h0;
  localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;
  // Bus synchronisation states
  typedef enum logic [2:0] {
    CBT_ST_HELD = 3'b001,
    CBT_ST_HUNT = 3'b010,
    CBT_ST_SYNC = 3'b100
  } cbt_state_t;
  // Levels reported by the protocol engine
  typedef struct packed {
    logic sleep_mode;
    logic [7:0] rx_err_count;
    logic [8:0] tx_err_count;
  } cbt_core_status_t;
  // One-cycle events from the protocol engine
  typedef struct packed {
    logic msg_received;
    logic [2:0] tx_sent;
    logic [2:0] tx_aborted;
  } cbt_core_event_t;
endpackage

// File: verif/cbt_bus_node.sv
// Model of the other nodes sharing the CAN bus.
// Assumes the bench asks for dominant levels in step with mclk.
`timescale 1ns/1ps
module cbt_bus_node (
  input wire logic mclk,
  input wire logic rst,
  input wire logic send_dominant,
  output logic bus_rx
);
  logic dom_q;
  // A node drives dominant only on request; the bus otherwise floats recessive
  always_ff @(posedge mclk)
  begin
    dom_q <= rst ? 1'b0 : send_dominant;
  end
  assign bus_rx = ~dom_q;
endmodule

// File: verif/test_can_bit_timing_and_status_flags.sv
// Self-checking bench for the CAN bit timing and status flag block.
// Assumes cbt_pkg, cbt_top and the bus node model are compiled first.
`timescale 1ns/1ps
module test_can_bit_timing_and_status_flags;
  import cbt_pkg::*;
  logic mclk, rst, awvalid, wvalid, arvalid, dom, bus_rx;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic sampled_bit, bit_tick, bus_synced, soft_out, fg_load;
  logic irq_w, irq_e, irq_r, irq_t;
  logic [2:0] abt_req;
  cbt_core_status_t st;
  cbt_core_event_t ev;
  int err_total, checked, fg_cnt;

  cbt_top dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .bus_rx(bus_rx),
    .core_status(st), .core_event(ev), .sampled_bit(sampled_bit), .bit_tick(bit_tick),
    .bus_synced(bus_synced), .soft_reset_out(soft_out), .fg_load(fg_load),
    .abort_request(abt_req), .irq_wakeup(irq_w), .irq_error(irq_e), .irq_receive(irq_r),
    .irq_transmit(irq_t));
  cbt_bus_node node (.mclk(mclk), .rst(rst), .send_dominant(dom), .bus_rx(bus_rx));

  // Clock at 40 MHz
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Count foreground loads seen on the port
  always @(posedge mclk)
  begin
    if (fg_load === 1'b1)
      fg_cnt++;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo();
    err_total++;
    complete_run();
  endtask

  // AXI4-Lite write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] ix, input logic [7:0] d,
    input logic [1:0] er = CBT_RESP_OKAY);
    int n;
    @(posedge mclk);
    awaddr <= {2'b00, ix, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (!bvalid);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // AXI4-Lite read and compare of data and response
  task automatic rd(input logic [7:0] ix, input logic [31:0] e, input string nm,
    input logic [1:0] er = CBT_RESP_OKAY);
    int n;
    @(posedge mclk);
    araddr <= {2'b00, ix, 2'b00};
    arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (!rvalid);
    chk(nm, e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // One-cycle event from the protocol engine
  task automatic pulse(input logic [6:0] e);
    @(posedge mclk);
    ev <= cbt_core_event_t'(e);
    @(posedge mclk);
    ev <= '0;
  endtask

  // Reset values, unmapped place, enables held in soft reset
  task automatic t_reset();
    rd(CBT_IDX_CTRL, 32'h01, "ctrl");
    rd(CBT_IDX_BTIME, 32'h00, "btime");
    rd(CBT_IDX_RFLG, 32'h00, "rflg");
    rd(CBT_IDX_TFLG, 32'h07, "tflg");
    rd(8'h09, 32'h00, "unmapped", CBT_RESP_SLVERR);
    wr(8'h09, 8'hff, CBT_RESP_SLVERR);
    wr(CBT_IDX_RIER, 8'hff);
    rd(CBT_IDX_RIER, 32'h00, "rier held");
  endtask

  // Bit period, write lock, triple sampling, sync and its loss
  task automatic t_timing();
    int n;
    wr(CBT_IDX_PRESC, 8'h01);
    wr(CBT_IDX_BTIME, 8'h93);
    rd(CBT_IDX_BTIME, 32'h93, "btime");
    wr(CBT_IDX_CTRL, 8'h00);
    wr(CBT_IDX_BTIME, 8'h25);
    rd(CBT_IDX_BTIME, 32'h93, "btime locked");
    n = 0;
    while (!bit_tick)
    begin
      @(posedge mclk);
      n++;
      if (n > 100) tmo();
    end
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (!bit_tick && n < 100);
    // Prescaler 2 times (sync 1 + first 4 + second 2) quanta
    chk("bit period", 32'd14, n);
    dom <= 1'b1;
    settle(3 * 14);
    chk("sampled bit", 32'h0, {31'h0, sampled_bit});
    dom <= 1'b0;
    n = 0;
    while (!bus_synced && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk("synced", 32'h1, {31'h0, bus_synced});
    chk("sampled bit", 32'h1, {31'h0, sampled_bit});
    rd(CBT_IDX_CTRL, 32'h10, "ctrl synced");
    wr(CBT_IDX_CTRL, 8'h01);
    settle(2);
    chk("synced", 32'h0, {31'h0, bus_synced});
    chk("soft out", 32'h1, {31'h0, soft_out});
    wr(CBT_IDX_CTRL, 8'h00);
  endtask

  // Error count thresholds, write-one-to-clear, sticky conditions
  task automatic t_errors();
    st.tx_err_count <= 9'd96;
    settle(3);
    rd(CBT_IDX_RFLG, 32'h00, "rflg at 96");
    st.tx_err_count <= 9'd97;
    settle(3);
    rd(CBT_IDX_RFLG, 32'h20, "rflg tx warn");
    wr(CBT_IDX_RFLG, 8'h20);
    rd(CBT_IDX_RFLG, 32'h20, "rflg cause holds");
    wr(CBT_IDX_RIER, 8'h20);
    settle(3);
    chk("irq error", 32'h1, {31'h0, irq_e});
    st.tx_err_count <= 9'd0;
    wr(CBT_IDX_RFLG, 8'h00);
    rd(CBT_IDX_RFLG, 32'h20, "rflg write zero");
    wr(CBT_IDX_RFLG, 8'h20);
    rd(CBT_IDX_RFLG, 32'h00, "rflg cleared");
    settle(3);
    chk("irq error", 32'h0, {31'h0, irq_e});
    st.rx_err_count <= 8'd97;
    settle(3);
    rd(CBT_IDX_RFLG, 32'h40, "rflg rx warn");
    wr(CBT_IDX_RFLG, 8'h40);
    rd(CBT_IDX_RFLG, 32'h40, "rflg rx warn holds");
    st.rx_err_count <= 8'd128;
    settle(3);
    rd(CBT_IDX_RFLG, 32'h50, "rflg rx passive");
    st.tx_err_count <= 9'd128;
    settle(3);
    rd(CBT_IDX_RFLG, 32'h58, "rflg tx passive");
    st.tx_err_count <= 9'd256;
    settle(3);
    rd(CBT_IDX_RFLG, 32'h5c, "rflg bus off");
    st.tx_err_count <= 9'd0;
    st.rx_err_count <= 8'd0;
    wr(CBT_IDX_RFLG, 8'hff);
    rd(CBT_IDX_RFLG, 32'h04, "rflg bus off stays");
  endtask

  // Receive full, background wait and overrun
  task automatic t_receive();
    wr(CBT_IDX_RIER, 8'h05);
    pulse(7'h40);
    settle(3);
    chk("fg loads", 32'd1, fg_cnt);
    chk("irq receive", 32'h1, {31'h0, irq_r});
    chk("irq error", 32'h1, {31'h0, irq_e});
    pulse(7'h40);
    pulse(7'h40);
    settle(3);
    chk("fg loads", 32'd1, fg_cnt);
    rd(CBT_IDX_RFLG, 32'h07, "rflg overrun");
    wr(CBT_IDX_RFLG, 8'h00);
    rd(CBT_IDX_RFLG, 32'h07, "rflg overrun zero write");
    wr(CBT_IDX_RFLG, 8'h02);
    rd(CBT_IDX_RFLG, 32'h05, "rflg full stays");
  endtask

  // Wakeup from bus activity in sleep
  task automatic t_wake();
    st.sleep_mode <= 1'b1;
    dom <= 1'b1;
    wr(CBT_IDX_RIER, 8'h81);
    rd(CBT_IDX_RFLG, 32'h85, "rflg wake");
    chk("irq wake", 32'h1, {31'h0, irq_w});
    wr(CBT_IDX_RFLG, 8'h80);
    rd(CBT_IDX_RFLG, 32'h85, "rflg wake holds");
    st.sleep_mode <= 1'b0;
    dom <= 1'b0;
    wr(CBT_IDX_RFLG, 8'h80);
    rd(CBT_IDX_RFLG, 32'h05, "rflg wake clear");
    settle(3);
    chk("irq wake", 32'h0, {31'h0, irq_w});
  endtask

  // Transmit flag access kinds and per-buffer enables
  task automatic t_tx();
    wr(CBT_IDX_TFLG, 8'h00);
    rd(CBT_IDX_TFLG, 32'h07, "tflg write zero");
    wr(CBT_IDX_TFLG, 8'h71);
    rd(CBT_IDX_TFLG, 32'h06, "tflg clear one");
    wr(CBT_IDX_TCTRL, 8'h11);
    settle(3);
    chk("irq transmit", 32'h0, {31'h0, irq_t});
    chk("abort request", 32'h1, {29'h0, abt_req});
    pulse(7'h08);
    settle(3);
    rd(CBT_IDX_TFLG, 32'h07, "tflg sent");
    chk("irq transmit", 32'h1, {31'h0, irq_t});
    chk("abort request", 32'h0, {29'h0, abt_req});
    wr(CBT_IDX_TFLG, 8'h02);
    // Aborted buffer: acknowledge is read-only and goes with its empty flag
    wr(CBT_IDX_TFLG, 8'h01);
    pulse(7'h01);
    rd(CBT_IDX_TFLG, 32'h15, "tflg aborted");
    wr(CBT_IDX_TFLG, 8'h70);
    rd(CBT_IDX_TFLG, 32'h15, "tflg abort read only");
    wr(CBT_IDX_TFLG, 8'h01);
    rd(CBT_IDX_TFLG, 32'h04, "tflg abort clear");
  endtask

  // Soft reset clears and holds flags and enables
  task automatic t_soft();
    wr(CBT_IDX_CTRL, 8'h01);
    settle(3);
    rd(CBT_IDX_RFLG, 32'h00, "rflg soft");
    rd(CBT_IDX_RIER, 32'h00, "rier soft");
    rd(CBT_IDX_TFLG, 32'h07, "tflg soft");
    chk("irqs", 32'h0, {28'h0, irq_w, irq_e, irq_r, irq_t});
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    tmo();
  end

  // Main sequence
  initial
  begin
    err_total = 0;
    checked = 0;
    fg_cnt = 0;
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    dom = 1'b0;
    st = '0;
    ev = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_timing();
    t_errors();
    t_receive();
    t_wake();
    t_tx();
    t_soft();
    complete_run();
  end
endmodule
